// ==== inc/rtc_time_pkg.sv ====
package rtc_time_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_MINUTE = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_SECOND = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h8;
  localparam int TENS_LSB = 4;
  localparam int TENS_MSB = 6;
  localparam int ONES_LSB = 0;
  localparam int ONES_MSB = 3;
  localparam int WEN_BIT = 0;
  localparam logic [2:0] TENS_MAX = 3'h5;
  localparam logic [3:0] ONES_MAX = 4'h9;
  localparam logic [6:0] TIME_RST = 7'h00;
  localparam logic WEN_RST = 1'b0;
endpackage

// ==== rtl/rtc_minute_second_regs.sv ====
// Behaviour
// - Minutes kept as BCD, tens in bits 6-4 (0-5), ones in 3-0 (0-9); the code stores written digits unchecked, tens up to 7, ones up to F.
// - Seconds tens digit is a 3-bit BCD field in bits 6-4, 0 to 5; the code stores any written value, 0 to 7.
// - Seconds ones digit is a 4-bit BCD field in bits 3-0, 0 to 9; the code stores any written value, 0 to F.
// - Minutes register accepts writes only while clock write enable is 1.
// - Seconds register accepts writes only while clock write enable is 1.
// - Bit 7 of minutes and seconds is unimplemented and reads zero.
`timescale 1ns/100ps
module rtc_minute_second_regs
  import rtc_time_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic time_load_i,
  input wire logic [6:0] minute_load_i,
  input wire logic [6:0] second_load_i,
  output logic [6:0] minute_value_o,
  output logic [6:0] second_value_o,
  output logic clock_write_enable_o
);

  // Stored time digits
  logic [6:0] minute_q;
  logic [6:0] minute_d;
  logic [6:0] second_q;
  logic [6:0] second_d;

  // Control bit
  logic clock_write_enable_q;
  logic clock_write_enable_d;

  // Bus answer state
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic ack_q;
  logic ack_d;

  // Address compare shared by every decoder
  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offset
  );
    addr_hit = (addr == offset);
  endfunction

  function automatic logic [6:0] bcd_pack(
    input logic [31:0] word
  );
    logic [2:0] tens;
    logic [3:0] ones;
    tens = word[TENS_MSB:TENS_LSB];
    ones = word[ONES_MSB:ONES_LSB];
    bcd_pack = {tens, ones};
  endfunction

  // time value with zero top bits
  function automatic logic [31:0] time_word(
    input logic [6:0] value
  );
    time_word = {25'h000_0000, value};
  endfunction

  // Control bit widened to a bus word
  function automatic logic [31:0] ctl_word(
    input logic value
  );
    ctl_word = {31'h0000_0000, value};
  endfunction

  // Request decode
  wire req_active;
  wire first_cycle;
  wire take_edge;
  wire lane0_on;
  wire wr_take;
  wire rd_first;

  // Register select
  wire sel_min;
  wire sel_sec;
  wire sel_ctl;

  // Write gates and data
  wire min_we;
  wire sec_we;
  wire ctl_we;
  wire [6:0] wr_digits;
  wire wr_enable_bit;

  // Read path
  wire [31:0] rd_mux;

  assign req_active = avs_read_i | avs_write_i;

  // One wait state: answer comes the cycle after the request
  assign first_cycle = req_active & ~ack_q;
  assign take_edge = req_active & ack_q;
  assign lane0_on = avs_byteenable_i[0];

  // Writes land at the edge where waitrequest is low
  assign wr_take = avs_write_i & take_edge & lane0_on;
  assign rd_first = avs_read_i & first_cycle;

  assign sel_min = addr_hit(avs_address_i, OFF_MINUTE);
  assign sel_sec = addr_hit(avs_address_i, OFF_SECOND);
  assign sel_ctl = addr_hit(avs_address_i, OFF_CTRL);

  assign min_we = wr_take & sel_min & clock_write_enable_q;
  assign sec_we = wr_take & sel_sec & clock_write_enable_q;
  assign ctl_we = wr_take & sel_ctl;

  assign wr_digits = bcd_pack(avs_writedata_i);
  assign wr_enable_bit = avs_writedata_i[WEN_BIT];

  // bit 7 and above read zero
  assign rd_mux = sel_min ? time_word(minute_q) :
                  sel_sec ? time_word(second_q) :
                  sel_ctl ? ctl_word(clock_write_enable_q) :
                  32'h0000_0000;

  // Handshake next state
  always_comb begin
    ack_d = first_cycle;
    rdata_d = rdata_q;
    if (rd_first) begin
      rdata_d = rd_mux;
    end
  end

  always_comb begin
    minute_d = minute_q;
    if (min_we) begin
      minute_d = wr_digits;
    end else if (time_load_i) begin
      minute_d = minute_load_i;
    end
  end

  always_comb begin
    second_d = second_q;
    if (sec_we) begin
      second_d = wr_digits;
    end else if (time_load_i) begin
      second_d = second_load_i;
    end
  end

  // Control bit next value
  always_comb begin
    clock_write_enable_d = clock_write_enable_q;
    if (ctl_we) begin
      clock_write_enable_d = wr_enable_bit;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      minute_q <= TIME_RST;
    end else begin
      minute_q <= minute_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      second_q <= TIME_RST;
    end else begin
      second_q <= second_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      clock_write_enable_q <= WEN_RST;
    end else begin
      clock_write_enable_q <= clock_write_enable_d;
    end
  end

  // Outputs
  assign avs_waitrequest_o = first_cycle;
  assign avs_readdata_o = rdata_q;
  assign minute_value_o = minute_q;
  assign second_value_o = second_q;
  assign clock_write_enable_o = clock_write_enable_q;

endmodule

// ==== tb/rtc_regs_checker.sv ====
`timescale 1ns/100ps
module rtc_regs_checker import rtc_time_pkg::*; (input wire logic clk_sys_i, srst_i,
  avs_read_i, avs_write_i, avs_waitrequest_o, clock_write_enable_o, time_load_i,
  input wire logic [ADDR_W-1:0] avs_address_i, input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i, avs_readdata_o,
  input wire logic [6:0] minute_value_o, second_value_o);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  wire wa = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  wire ra = avs_read_i && !avs_waitrequest_o;
  wire am = avs_address_i == OFF_MINUTE;
  wire asec = avs_address_i == OFF_SECOND;
  min_write_a: assert property (wa && am && clock_write_enable_o |=>
    minute_value_o == $past(avs_writedata_i[6:0])) else $error("minute write lost");
  sec_write_a: assert property (wa && asec && clock_write_enable_o |=>
    second_value_o == $past(avs_writedata_i[6:0])) else $error("second write lost");
  locked_hold_a: assert property (wa && (am || asec) && !clock_write_enable_o
    && !time_load_i |=> $stable({minute_value_o, second_value_o})) else $error("locked write");
  top_zero_a: assert property (ra && (am || asec) |-> avs_readdata_o[31:7] == 0)
    else $error("bit 7 not zero");
  min_read_a: assert property (ra && am |-> avs_readdata_o[6:0] == minute_value_o)
    else $error("minute readback");
  sec_tens_a: assert property (ra && asec |-> avs_readdata_o[6:4] == second_value_o[6:4])
    else $error("seconds tens");
  sec_ones_a: assert property (ra && asec |-> avs_readdata_o[3:0] == second_value_o[3:0])
    else $error("seconds ones");
endmodule
bind rtc_minute_second_regs rtc_regs_checker chk_u (.*);

// ==== tb/rtc_minute_second_regs_test.sv ====
`timescale 1ns/100ps
module rtc_minute_second_regs_test import rtc_time_pkg::*;;
  logic clk_sys_i = 0, srst_i = 1, avs_read_i = 0, avs_write_i = 0;
  logic [3:0] avs_address_i = 0;
  logic [31:0] avs_writedata_i = 0, d;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, clock_write_enable_o;
  wire [6:0] minute_value_o, second_value_o;
  logic time_load_i = 0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [6:0] minute_load_i = 0, second_load_i = 0;
  int fails = 0, total_checks = 0;
  // Address, enable, write data, readback
  logic [23:0] rows [5] = '{24'h01_5959, 24'h41_4545, 24'h01_FF7F, 24'h00_127F, 24'h40_3345};
  always #12.5 clk_sys_i = ~clk_sys_i;
  rtc_minute_second_regs dut_u (.*);
  task chk(input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %0t read %h want %h", $time, s, e);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk_sys_i);
    avs_address_i <= a; avs_writedata_i <= wd; avs_write_i <= w; avs_read_i <= !w;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o; avs_write_i <= 0; avs_read_i <= 0;
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_i);
    srst_i <= 0;
    bus(0, OFF_MINUTE, 0); chk(d, 0);
    foreach (rows[i]) begin
      bus(1, OFF_CTRL, rows[i][16]);
      bus(1, rows[i][23:20], rows[i][15:8]);
      bus(0, rows[i][23:20], 0); chk(d, rows[i][7:0]);
      chk(rows[i][22] ? second_value_o : minute_value_o, rows[i][6:0]);
      chk(clock_write_enable_o, rows[i][16]);
    end
    bus(0, 4'hC, 0); chk(d, 0);
    bus(1, OFF_CTRL, 1); avs_byteenable_i <= 4'hE;
    bus(1, OFF_MINUTE, 32'h0000_0021); avs_byteenable_i <= 4'hF;
    bus(0, OFF_MINUTE, 0); chk(d, 32'h0000_007F);
    @(posedge clk_sys_i);
    time_load_i <= 1; minute_load_i <= 7'h34; second_load_i <= 7'h56;
    @(posedge clk_sys_i);
    time_load_i <= 0;
    @(posedge clk_sys_i);
    chk(minute_value_o, 7'h34);
    chk(second_value_o, 7'h56);
    bus(0, OFF_SECOND, 0); chk(d, 32'h0000_0056);
    srst_i <= 1;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 0;
    @(posedge clk_sys_i);
    chk(minute_value_o, 0);
    chk(second_value_o, 0);
    chk(clock_write_enable_o, 0);
    chk(avs_waitrequest_o, 0);
    bus(1, OFF_SECOND, 32'h0000_0017); bus(0, OFF_SECOND, 0); chk(d, 0);
    end_of_test;
  end
  initial begin #100000; fails++; end_of_test; end
endmodule
